/* File: pkg/sts_map.svh */
/*
 Bit positions, reset values and exception numbers of the status word
 and the two exception masks. Assumes inclusion by the package and rtl.
*/
`ifndef STS_MAP_SVH
`define STS_MAP_SVH

// ----------------------------------------------------------------
// Combined word layout
// ----------------------------------------------------------------
`define STS_N_BIT       31
`define STS_Z_BIT       30
`define STS_C_BIT       29
`define STS_V_BIT       28
`define STS_Q_BIT       27
`define STS_NZCVQ_HI    31
`define STS_NZCVQ_LO    27
`define STS_GE_HI       19
`define STS_GE_LO       16
`define STS_EXC_HI      8
`define STS_EXC_LO      0
`define STS_T_BIT       24
`define STS_CB_HI_HI    26
`define STS_CB_HI_LO    25
`define STS_CB_LO_HI    15
`define STS_CB_LO_LO    10

// ----------------------------------------------------------------
// Reset values and exception numbers
// ----------------------------------------------------------------
`define STS_WORD_RST    32'h0100_0000
`define STS_T_RST       1'h1
`define STS_EXC_RST     9'h000
`define STS_MASK_RST    1'h0
`define STS_EXC_THREAD  9'h000
`define STS_EXC_NMI     9'h002
`define STS_EXC_HARD    9'h003
`define STS_EXC_IRQ0    9'h010
`define STS_EXC_IRQMAX  9'h100

`endif

/* File: pkg/sts_pkg.sv */
/*
 Types shared by the status register file and its helpers.
 Assumes sts_map.svh sits on the include path.
*/
package sts_pkg;
  `include "sts_map.svh"

  // Register selectors of the special-register moves
  typedef enum logic [3:0] {
    SEL_COMBINED,
    SEL_FLAGS,
    SEL_EXCNUM,
    SEL_EXEC,
    SEL_EXEC_EXC,
    SEL_FLAGS_EXC,
    SEL_FLAGS_EXEC,
    SEL_FLAG_ONLY,
    SEL_PRIO_MASK,
    SEL_FAULT_MASK
  } sts_sel_t;

  // Special-register move request
  typedef struct packed {
    logic        req;
    logic        wr;
    sts_sel_t    sel;
    logic [31:0] wdata;
  } sts_mov_t;

  // Change-processor-state request
  typedef struct packed {
    logic valid;
    logic fault;
    logic set;
  } sts_chg_t;

  // Flag results from the execute stage
  typedef struct packed {
    logic       valid;
    logic [4:0] nzcvq;
    logic       ge_valid;
    logic [3:0] ge;
  } sts_alu_t;

  // Exception entry and return
  typedef struct packed {
    logic        entry;
    logic        vec_bit0;
    logic [8:0]  num;
    logic        ret;
    logic [8:0]  ret_num;
    logic [31:0] ret_word;
  } sts_exc_t;
endpackage

/* File: rtl/sts_act_gate.sv */
/*
 Activation gate of a pending exception under the two masks.
 Assumes the pending number and priority class come from the controller.
*/
`timescale 1ns/1ps
`include "sts_map.svh"
module sts_act_gate
  import sts_pkg::*;
(
  input  wire logic       pend,
  input  wire logic [8:0] pend_num,
  input  wire logic       pend_cfg,
  input  wire logic       prio_mask,
  input  wire logic       fault_mask,
  output logic            allow
);
  // Masks only block; zero means no effect
  always_comb begin
    allow = pend;
    if (prio_mask && pend_cfg) begin
      allow = 1'b0;
    end
    if (fault_mask && (pend_num != `STS_EXC_NMI)) begin
      allow = 1'b0;
    end
  end
endmodule

/* File: rtl/sts_cond_unit.sv */
/*
 Conditional-block and resumable-multiple state holder.
 Assumes one request kind per cycle from the core; clear wins otherwise.
*/
`timescale 1ns/1ps
module sts_cond_unit
  import sts_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       step,
  input  wire logic       save,
  input  wire logic [3:0] save_reg,
  output logic [7:0]      state
);
  logic [7:0] state_r;
  logic [7:0] state_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (clr) begin
      state_nxt = 8'h00;
    end else if (load) begin
      state_nxt = load_val;
    end else if (save) begin
      state_nxt = {save_reg, 4'h0};
    end else if (step) begin
      // Block ends after its last slot; at most four slots
      if (state_r[2:0] == 3'h0) begin
        state_nxt = 8'h00;
      end else begin
        state_nxt = {state_r[7:5], state_r[3:0], 1'b0};
      end
    end
  end

  // Register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= 8'h00;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign state = state_r;
endmodule

/* File: rtl/sts_regs.sv */
/*
 Core status word, its three views and the two exception masks.
 Assumes same-clock requests from decode, execute and the exception
 controller; all inputs are already synchronous to clk.
*/
`timescale 1ns/1ps
`include "sts_map.svh"
module sts_regs
  import sts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire sts_mov_t    mov,
  output logic [31:0]      mov_rdata,
  output logic             mov_rvalid,
  input  wire sts_chg_t    chg,
  input  wire sts_alu_t    alu,
  input  wire sts_exc_t    exc,
  input  wire logic        rv_valid,
  input  wire logic        rv_bit0,
  input  wire logic        xchg_valid,
  input  wire logic        xchg_bit0,
  input  wire logic        cb_load,
  input  wire logic [7:0]  cb_val,
  input  wire logic        cb_step,
  input  wire logic        multi_save,
  input  wire logic [3:0]  multi_reg,
  input  wire logic        multi_done,
  input  wire logic        exec_try,
  input  wire logic        pend,
  input  wire logic [8:0]  pend_num,
  input  wire logic        pend_cfg,
  output logic             pend_allow,
  output logic [31:0]      status_word,
  output logic             prio_mask,
  output logic             fault_mask,
  output logic [3:0]       cond_code,
  output logic             cond_active,
  output logic             multi_active,
  output logic [3:0]       multi_next_reg,
  output logic             tstate_fault
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Build the word from its fields; zeros elsewhere
  function automatic logic [31:0] pack_word(
    input logic [4:0] nzcvq,
    input logic [3:0] ge,
    input logic [8:0] num,
    input logic       tb,
    input logic [7:0] cb
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`STS_NZCVQ_HI:`STS_NZCVQ_LO] = nzcvq;
    w[`STS_GE_HI:`STS_GE_LO]       = ge;
    w[`STS_EXC_HI:`STS_EXC_LO]     = num;
    w[`STS_T_BIT]                  = tb;
    w[`STS_CB_HI_HI:`STS_CB_HI_LO] = cb[1:0];
    w[`STS_CB_LO_HI:`STS_CB_LO_LO] = cb[7:2];
    return w;
  endfunction

  // Block state out of a stacked word
  function automatic logic [7:0] cb_of(input logic [31:0] w);
    return {w[`STS_CB_LO_HI:`STS_CB_LO_LO],
            w[`STS_CB_HI_HI:`STS_CB_HI_LO]};
  endfunction

  // Selector includes the flags view
  function automatic logic has_flags(input sts_sel_t s);
    return (s == SEL_COMBINED) || (s == SEL_FLAGS) ||
           (s == SEL_FLAGS_EXC) || (s == SEL_FLAGS_EXEC) ||
           (s == SEL_FLAG_ONLY);
  endfunction

  // Selector includes the exception-number view
  function automatic logic has_exc(input sts_sel_t s);
    return (s == SEL_COMBINED) || (s == SEL_EXCNUM) ||
           (s == SEL_EXEC_EXC) || (s == SEL_FLAGS_EXC);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0]  nzcvq_r;
  logic [4:0]  nzcvq_nxt;
  logic [3:0]  ge_r;
  logic [3:0]  ge_nxt;
  logic [8:0]  exc_r;
  logic [8:0]  exc_nxt;
  logic        tbit_r;
  logic        tbit_nxt;
  logic        pmask_r;
  logic        pmask_nxt;
  logic        fmask_r;
  logic        fmask_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic        tflt_r;
  logic        tflt_nxt;
  logic [7:0]  cb_state;
  logic        mov_wr;
  logic        cb_clr;
  logic        cb_ld;
  logic [7:0]  cb_ld_val;

  assign mov_wr = mov.req && mov.wr;

  // ----------------------------------------------------------------
  // Condition flags
  // ----------------------------------------------------------------

  // Return restore, then move write, then execute results
  always_comb begin
    nzcvq_nxt = nzcvq_r;
    ge_nxt    = ge_r;
    if (exc.ret) begin
      nzcvq_nxt = exc.ret_word[`STS_NZCVQ_HI:`STS_NZCVQ_LO];
      ge_nxt    = exc.ret_word[`STS_GE_HI:`STS_GE_LO];
    end else if (mov_wr && has_flags(mov.sel)) begin
      nzcvq_nxt = mov.wdata[`STS_NZCVQ_HI:`STS_NZCVQ_LO];
      if (mov.sel != SEL_FLAG_ONLY) begin
        ge_nxt = mov.wdata[`STS_GE_HI:`STS_GE_LO];
      end
    end else begin
      if (alu.valid) begin
        nzcvq_nxt = alu.nzcvq;
      end
      if (alu.ge_valid) begin
        ge_nxt = alu.ge;
      end
    end
  end

  // Flags register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nzcvq_r <= 5'h00;
      ge_r    <= 4'h0;
    end else if (ce) begin
      nzcvq_r <= nzcvq_nxt;
      ge_r    <= ge_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Active exception number
  // ----------------------------------------------------------------

  // Only the exception controller moves it; moves never do
  always_comb begin
    exc_nxt = exc_r;
    if (exc.entry) begin
      exc_nxt = exc.num;
    end else if (exc.ret) begin
      exc_nxt = exc.ret_num;
    end
  end

  // Number register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exc_r <= `STS_EXC_RST;
    end else if (ce) begin
      exc_r <= exc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------

  // Set-state bit follows vectors, exchanges and returns only
  always_comb begin
    tbit_nxt = tbit_r;
    tflt_nxt = 1'b0;
    if (rv_valid) begin
      tbit_nxt = rv_bit0;
    end else if (exc.entry) begin
      tbit_nxt = exc.vec_bit0;
    end else if (exc.ret) begin
      tbit_nxt = exc.ret_word[`STS_T_BIT];
    end else if (xchg_valid) begin
      tbit_nxt = xchg_bit0;
    end
    if (exec_try && !tbit_r) begin
      tflt_nxt = 1'b1;
    end
  end

  // Set-state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tbit_r <= `STS_T_RST;
      tflt_r <= 1'b0;
    end else if (ce) begin
      tbit_r <= tbit_nxt;
      tflt_r <= tflt_nxt;
    end
  end

  // Block state: entry clears, return restores, decode loads
  assign cb_clr    = exc.entry || rv_valid || multi_done;
  assign cb_ld     = exc.ret || cb_load;
  assign cb_ld_val = exc.ret ? cb_of(exc.ret_word) : cb_val;

  // Conditional and resumable state holder
  sts_cond_unit u_cond (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .clr      (cb_clr),
    .load     (cb_ld),
    .load_val (cb_ld_val),
    .step     (cb_step),
    .save     (multi_save),
    .save_reg (multi_reg),
    .state    (cb_state)
  );

  // ----------------------------------------------------------------
  // Exception masks
  // ----------------------------------------------------------------

  // Leaving a non-NMI handler clears the fault mask over a same-cycle write
  always_comb begin
    pmask_nxt = pmask_r;
    fmask_nxt = fmask_r;
    // Move writes keep bit 0 only; upper bits are dropped
    if (mov_wr && (mov.sel == SEL_PRIO_MASK)) begin
      pmask_nxt = mov.wdata[0];
    end
    if (mov_wr && (mov.sel == SEL_FAULT_MASK)) begin
      fmask_nxt = mov.wdata[0];
    end
    if (chg.valid) begin
      if (chg.fault) begin
        fmask_nxt = chg.set;
      end else begin
        pmask_nxt = chg.set;
      end
    end
    if (exc.ret && (exc_r != `STS_EXC_NMI)) begin
      fmask_nxt = 1'b0;
    end
  end

  // Mask register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pmask_r <= `STS_MASK_RST;
      fmask_r <= `STS_MASK_RST;
    end else if (ce) begin
      pmask_r <= pmask_nxt;
      fmask_r <= fmask_nxt;
    end
  end

  // Activation gate for the pending exception
  sts_act_gate u_gate (
    .pend       (pend),
    .pend_num   (pend_num),
    .pend_cfg   (pend_cfg),
    .prio_mask  (pmask_r),
    .fault_mask (fmask_r),
    .allow      (pend_allow)
  );

  // ----------------------------------------------------------------
  // Move read port
  // ----------------------------------------------------------------

  // Views masked per selector; execution bits always zero
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = mov.req && !mov.wr;
    if (mov.req && !mov.wr) begin
      // Mask reads show bit 0 only
      if (mov.sel == SEL_PRIO_MASK) begin
        rdata_nxt = {31'h0, pmask_r};
      end else if (mov.sel == SEL_FAULT_MASK) begin
        rdata_nxt = {31'h0, fmask_r};
      end else begin
        rdata_nxt = pack_word(
          has_flags(mov.sel) ? nzcvq_r : 5'h00,
          has_flags(mov.sel) ? ge_r : 4'h0,
          has_exc(mov.sel) ? exc_r : 9'h000,
          1'b0,
          8'h00);
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mov_rdata      = rdata_r;
  assign mov_rvalid     = rvalid_r;
  assign status_word    = pack_word(nzcvq_r, ge_r, exc_r,
                                    tbit_r, cb_state);
  assign prio_mask      = pmask_r;
  assign fault_mask     = fmask_r;
  assign cond_active    = cb_state[3:0] != 4'h0;
  assign cond_code      = cb_state[7:4];
  assign multi_active   = (cb_state[3:0] == 4'h0) &&
                          (cb_state[7:4] != 4'h0);
  assign multi_next_reg = cb_state[7:4];
  assign tstate_fault   = tflt_r;
endmodule

/* File: testbench/sts_regs_checker.sv */
/*
 Concurrent checks on the status word, move reads and the masks.
 Assumes it is bound onto sts_regs, with one clock domain.
*/
`timescale 1ns/1ps
module sts_regs_checker
  import sts_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire sts_mov_t    mov,
  input wire logic [31:0] mov_rdata,
  input wire logic        mov_rvalid,
  input wire sts_alu_t    alu,
  input wire sts_exc_t    exc,
  input wire logic        rv_valid,
  input wire logic        rv_bit0,
  input wire logic        cb_load,
  input wire logic        multi_save,
  input wire logic [3:0]  multi_reg,
  input wire logic        multi_done,
  input wire logic        exec_try,
  input wire logic        pend,
  input wire logic [8:0]  pend_num,
  input wire logic        pend_cfg,
  input wire logic        pend_allow,
  input wire logic [31:0] status_word,
  input wire logic        prio_mask,
  input wire logic        fault_mask,
  input wire logic        multi_active,
  input wire logic [3:0]  multi_next_reg,
  input wire logic        tstate_fault
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dflt @(posedge clk); endclocking
  default disable iff (!rstn);

  // Read request and its answer
  sequence s_rd_req;
    ce && mov.req && !mov.wr;
  endsequence
  sequence s_rd_ans;
    mov_rvalid && mov_rdata[26:24] == 3'h0 && mov_rdata[15:10] == 6'h00;
  endsequence
  // Interrupted multiple transfer and the state it leaves
  sequence s_save_req;
    ce && multi_save && multi_reg != 4'h0
      && !(exc.entry || exc.ret || rv_valid || multi_done || cb_load);
  endsequence
  sequence s_save_held;
    multi_active && multi_next_reg == $past(multi_reg)
      && status_word[26:25] == 2'h0 && status_word[11:10] == 2'h0;
  endsequence

  chk_read_answer: assert property (s_rd_req |=> s_rd_ans)
    else $error("read answer missing or exec bits not zero");
  chk_resv_zero: assert property (
    mov_rvalid |-> mov_rdata[23:20] == 4'h0 && mov_rdata[9] == 1'h0)
    else $error("reserved read bits not zero");
  chk_prio_block: assert property (
    pend && pend_cfg && prio_mask |-> !pend_allow)
    else $error("priority mask let exception through");
  chk_fault_block: assert property (
    pend && fault_mask |-> pend_allow == (pend_num == 9'h002))
    else $error("fault mask gating wrong");
  chk_fault_exit: assert property (
    ce && exc.ret && status_word[8:0] != 9'h002 |=> !fault_mask)
    else $error("fault mask not cleared on handler exit");
  chk_excnum_hold: assert property (
    ce && mov.req && mov.wr && !exc.entry && !exc.ret |=> $stable(status_word[8:0]))
    else $error("move write changed exception number");
  chk_flag_only: assert property (
    ce && mov.req && mov.wr && mov.sel == SEL_FLAG_ONLY && !exc.ret && !alu.ge_valid
    |=> status_word[31:27] == $past(mov.wdata[31:27]) && $stable(status_word[19:16]))
    else $error("flag only write wrong");
  chk_tstate_fault: assert property (
    ce && exec_try |=> tstate_fault == !$past(status_word[24]))
    else $error("state fault pulse wrong");
  chk_multi_save: assert property (s_save_req |=> s_save_held)
    else $error("resumable state not recorded");
  chk_reset_tbit: assert property (
    ce && rv_valid |=> status_word[24] == $past(rv_bit0))
    else $error("reset vector bit not copied");
endmodule

bind sts_regs sts_regs_checker chk_u (.clk, .rstn, .ce, .mov, .mov_rdata, .mov_rvalid,
  .alu, .exc, .rv_valid, .rv_bit0, .cb_load, .multi_save, .multi_reg, .multi_done,
  .exec_try, .pend, .pend_num, .pend_cfg, .pend_allow, .status_word, .prio_mask,
  .fault_mask, .multi_active, .multi_next_reg, .tstate_fault);

/* File: testbench/sts_regs_tb.sv */
/*
 Directed bench for the status register file.
 Assumes sts_pkg compiled first and the checker bound.
*/
`timescale 1ns/1ps
module sts_regs_tb
  import sts_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic        clk, rstn, ce, mov_rvalid, rv_valid, rv_bit0, xchg_valid, xchg_bit0;
  logic        cb_load, cb_step, multi_save, multi_done, exec_try, pend, pend_cfg;
  logic        pend_allow, prio_mask, fault_mask, cond_active, multi_active;
  logic        tstate_fault;
  logic [3:0]  multi_reg, cond_code, multi_next_reg;
  logic [7:0]  cb_val;
  logic [8:0]  pend_num;
  logic [31:0] mov_rdata, status_word;
  logic [31:0] rexp [7];
  sts_mov_t    mov;
  sts_chg_t    chg;
  sts_alu_t    alu;
  sts_exc_t    exc;
  int          err_count, compares;

  sts_regs dut_u (.clk, .rstn, .ce, .mov, .mov_rdata, .mov_rvalid, .chg, .alu, .exc,
    .rv_valid, .rv_bit0, .xchg_valid, .xchg_bit0, .cb_load, .cb_val, .cb_step,
    .multi_save, .multi_reg, .multi_done, .exec_try, .pend, .pend_num, .pend_cfg,
    .pend_allow, .status_word, .prio_mask, .fault_mask, .cond_code, .cond_active,
    .multi_active, .multi_next_reg, .tstate_fault);

  // Clock and watchdog
  always #5 clk = ~clk;
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end

  // Helpers for timing, compares and moves
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input sts_sel_t s, input logic [31:0] e);
    tick();
    mov = '{1'h1, 1'h0, s, 32'h0000_0000};
    tick();
    mov = '0;
    chk("rvalid", 32'h1, {31'h0, mov_rvalid});
    chk(s.name(), e, mov_rdata);
  endtask
  task automatic wr(input sts_sel_t s, input logic [31:0] d);
    tick();
    mov = '{1'h1, 1'h1, s, d};
    tick();
    mov = '0;
  endtask
  task automatic chg_ev(input logic f, input logic s);
    tick();
    chg = '{1'h1, f, s};
    tick();
    chg = '0;
  endtask
  task automatic exc_ev(input sts_exc_t e);
    tick();
    exc = e;
    tick();
    exc = '0;
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {clk, rstn, rv_valid, rv_bit0, xchg_valid, xchg_bit0, cb_load, cb_step} = '0;
    {multi_save, multi_done, exec_try, pend, pend_cfg, multi_reg, cb_val} = '0;
    {pend_num, mov, chg, alu, exc, err_count, compares} = '0;
    ce = 1'h1;
    repeat (16) @(posedge clk);
    #1 rstn = 1'h1;
    chk("word", 32'h0100_0000, status_word);
    chk("masks", 32'h0, {30'h0, prio_mask, fault_mask});
    rd(SEL_COMBINED, 32'h0000_0000);
    tick();
    ce = 1'h0;
    wr(SEL_COMBINED, 32'hFFFF_FFFF);
    chk("frozen", 32'h0100_0000, status_word);
    ce = 1'h1;
    $display("test reset done");
    wr(SEL_COMBINED, 32'hFFFF_FFFF);
    chk("word", 32'hF90F_0000, status_word);
    wr(SEL_FLAG_ONLY, 32'h0000_0000);
    chk("word", 32'h010F_0000, status_word);
    wr(SEL_FLAGS_EXC, 32'hA000_0000);
    chk("word", 32'hA100_0000, status_word);
    tick();
    alu = '{1'h1, 5'h03, 1'h1, 4'h5};
    tick();
    alu = '0;
    chk("word", 32'h1905_0000, status_word);
    exc_ev('{1'h1, 1'h1, 9'h100, 1'h0, 9'h000, 32'h0});
    chk("word", 32'h1905_0100, status_word);
    for (int i = 2; i < 5; i++) begin
      wr(sts_sel_t'(i), 32'h0000_0000);
      chk("word", 32'h1905_0100, status_word);
    end
    rexp = '{32'h1805_0100, 32'h1805_0000, 32'h100, 32'h0, 32'h100, 32'h1805_0100,
             32'h1805_0000};
    for (int i = 0; i < 7; i++) rd(sts_sel_t'(i), rexp[i]);
    $display("test moves done");
    chg_ev(1'h0, 1'h1);
    chk("prio", 32'h1, {31'h0, prio_mask});
    {pend, pend_cfg, pend_num} = {2'h3, 9'h010};
    tick();
    chk("allow", 32'h0, {31'h0, pend_allow});
    pend_cfg = 1'h0;
    tick();
    chk("allow", 32'h1, {31'h0, pend_allow});
    chg_ev(1'h1, 1'h1);
    pend_num = 9'h005;
    tick();
    chk("allow", 32'h0, {31'h0, pend_allow});
    pend_num = 9'h002;
    tick();
    chk("allow", 32'h1, {31'h0, pend_allow});
    pend = 1'h0;
    exc_ev('{1'h0, 1'h0, 9'h000, 1'h1, 9'h000, 32'h0100_0000});
    chk("fault", 32'h0, {31'h0, fault_mask});
    chg_ev(1'h1, 1'h1);
    exc_ev('{1'h1, 1'h1, 9'h002, 1'h0, 9'h000, 32'h0});
    exc_ev('{1'h0, 1'h0, 9'h000, 1'h1, 9'h000, 32'h0100_0000});
    chk("fault", 32'h1, {31'h0, fault_mask});
    chg_ev(1'h1, 1'h0);
    chg_ev(1'h0, 1'h0);
    chk("masks", 32'h0, {30'h0, prio_mask, fault_mask});
    wr(SEL_PRIO_MASK, 32'hFFFF_FFFF);
    chk("word", 32'h0100_0000, status_word);
    rd(SEL_PRIO_MASK, 32'h0000_0001);
    wr(SEL_FAULT_MASK, 32'h0000_0001);
    rd(SEL_FAULT_MASK, 32'h0000_0001);
    chk("masks", 32'h3, {30'h0, prio_mask, fault_mask});
    wr(SEL_PRIO_MASK, 32'h0000_0000);
    wr(SEL_FAULT_MASK, 32'h0000_0000);
    chk("masks", 32'h0, {30'h0, prio_mask, fault_mask});
    $display("test masks done");
    tick();
    xchg_valid = 1'h1;
    tick();
    xchg_valid = 1'h0;
    chk("tbit", 32'h0, {31'h0, status_word[24]});
    tick();
    exec_try = 1'h1;
    tick();
    exec_try = 1'h0;
    chk("tfault", 32'h1, {31'h0, tstate_fault});
    {rv_valid, rv_bit0} = 2'h3;
    tick();
    rv_valid = 1'h0;
    chk("tbit", 32'h1, {31'h0, status_word[24]});
    exc_ev('{1'h0, 1'h0, 9'h000, 1'h1, 9'h000, 32'h0});
    chk("tbit", 32'h0, {31'h0, status_word[24]});
    {xchg_valid, xchg_bit0} = 2'h3;
    tick();
    xchg_valid = 1'h0;
    chk("tbit", 32'h1, {31'h0, status_word[24]});
    $display("test state bit done");
    {multi_save, multi_reg} = 5'h1A;
    tick();
    multi_save = 1'h0;
    chk("multi", 32'h1A, {27'h0, multi_active, multi_next_reg});
    chk("zeros", 32'h0, {28'h0, status_word[26:25], status_word[11:10]});
    multi_done = 1'h1;
    tick();
    multi_done = 1'h0;
    chk("multi", 32'h0, {31'h0, multi_active});
    {cb_load, cb_val} = 9'h151;
    tick();
    cb_load = 1'h0;
    chk("code", 32'h15, {27'h0, cond_active, cond_code});
    for (int i = 1; i < 5; i++) begin
      tick();
      cb_step = 1'h1;
      tick();
      cb_step = 1'h0;
      chk("active", {31'h0, i < 4}, {31'h0, cond_active});
    end
    $display("test block state done");
    give_verdict();
  end
endmodule
